/* File: rtl/rlpc_pkg.sv */
// Package with register map, field positions and timing constants.
package rlpc_pkg;
    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [3:0] ADDR_WAKEUP = 4'h0;
    localparam logic [3:0] ADDR_POWER = 4'h4;
    localparam logic [3:0] ADDR_PENDING = 4'h8;
    // Width of the register bus address ports.
    localparam int ADDR_WAKEUP_W = 4;
    // Wakeup timer register fields.
    localparam int WK_FLAG_BIT = 7;
    localparam int WK_ACK_BIT = 6;
    localparam int WK_CLKS_BIT = 5;
    localparam int WK_IE_BIT = 4;
    localparam int WK_SEL_LSB = 0;
    // Power monitor register fields.
    localparam int LV_FLAG_BIT = 7;
    localparam int LV_ACK_BIT = 6;
    localparam int LV_IE_BIT = 5;
    localparam int LV_RE_BIT = 4;
    localparam int LV_SE_BIT = 3;
    localparam int LV_DE_BIT = 2;
    localparam int LV_BG_BIT = 0;
    // Pending summary fields.
    localparam int PD_CMP_BIT = 5;
    localparam int PD_CONV_BIT = 4;
    localparam int PD_TPM_BIT = 3;
    localparam int PD_MT2_BIT = 2;
    localparam int PD_MT1_BIT = 1;
    localparam int PD_WK_BIT = 0;
    // Reset values.
    localparam logic [7:0] WAKEUP_RESET = 8'h00;
    localparam logic [7:0] POWER_RESET = 8'h00;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing: bus clock rate and internal 1 kHz tick period.
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_HZ = 1_000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    // Delay codes.
    localparam logic [2:0] SEL_OFF = 3'h0;
    // Counter width, enough for 32768 source periods.
    localparam int CNT_W = 16;
endpackage : rlpc_pkg

/* File: rtl/rlpc_sysctl.sv */
// System control block: wakeup timer, power monitor and pending summary.
// Function
// - Wakeup interrupt enable bit 4, read-write.
// - Delay code 000 stops and clears counter.
// - Internal source codes map 8ms to 1.024s.
// - External codes map 256 to 32768 periods.
// - Low-voltage flag set only when detection enabled.
// - Write 1 to bit 6 clears flag.
// - Interrupt request when flag and enable set.
// - Reset enable forces system reset on flag.
// - Stop enable keeps detection alive in stop.
// - Detect enable gates all other controls except bit 0, the reference buffer.
// - Write-once bits accept only first write.
// - Bit 0 turns reference buffer on.
// - Pending 5 is comparator flag AND enable.
// - Pending 4 is conversion flag AND enable.
// - Pending 3 ORs three timer/PWM terms.
// - Pending 2 is second modulo timer pair.
// - Pending 1 is first modulo timer pair.
// - Pending 0 is wakeup flag AND enable.
// - Wakeup flag sets on period reached.
// - Write 1 to bit 6 clears wakeup flag.
// - Clock select picks internal or external.
`timescale 1ns/1ps
module rlpc_sysctl #(
    parameter int TICK_DIV = rlpc_pkg::TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rlpc_pkg::ADDR_WAKEUP_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rlpc_pkg::ADDR_WAKEUP_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_clk_pin,
    input wire logic low_voltage_event,
    input wire logic stop_mode,
    input wire logic comparator_flag,
    input wire logic comparator_irq_enable,
    input wire logic conversion_complete_flag,
    input wire logic converter_irq_enable,
    input wire logic overflow_flag,
    input wire logic overflow_irq_enable,
    input wire logic channel0_flag,
    input wire logic channel0_irq_enable,
    input wire logic channel1_flag,
    input wire logic channel1_irq_enable,
    input wire logic mt1_overflow_flag,
    input wire logic mt1_overflow_irq_enable,
    input wire logic mt2_overflow_flag,
    input wire logic mt2_overflow_irq_enable,
    output logic wakeup_irq,
    output logic low_voltage_irq,
    output logic low_voltage_reset,
    output logic low_voltage_detect_on,
    output logic reference_buffer_on
);
    import rlpc_pkg::*;

    // Period in source counts for a delay code; zero means stopped.
    function automatic logic [CNT_W-1:0] period_of(input logic [2:0] code,
                                                   input logic ext);
        logic [CNT_W-1:0] p;
        p = '0;
        if (ext) begin
            case (code)
                3'h1: p = 16'h0100;
                3'h2: p = 16'h0400;
                3'h3: p = 16'h0800;
                3'h4: p = 16'h1000;
                3'h5: p = 16'h2000;
                3'h6: p = 16'h4000;
                3'h7: p = 16'h8000;
                default: p = '0;
            endcase
        end else begin
            case (code)
                3'h1: p = 16'h0008;
                3'h2: p = 16'h0020;
                3'h3: p = 16'h0040;
                3'h4: p = 16'h0080;
                3'h5: p = 16'h0100;
                3'h6: p = 16'h0200;
                3'h7: p = 16'h0400;
                default: p = '0;
            endcase
        end
        return p;
    endfunction

    // Control and status storage.
    logic wk_flag_r; // Wakeup timeout flag.
    logic wk_clks_r; // Wakeup clock select.
    logic wk_ie_r; // Wakeup interrupt enable.
    logic [2:0] wk_sel_r; // Wakeup delay select.
    logic lv_flag_r; // Low-voltage flag.
    logic lv_ie_r; // Low-voltage interrupt enable.
    logic lv_re_r; // Low-voltage reset enable, write-once.
    logic lv_se_r; // Low-voltage stop enable.
    logic lv_de_r; // Low-voltage detect enable, write-once.
    logic lv_bg_r; // Reference buffer enable.
    logic pm_locked_r; // Set after the first power register write.
    logic [CNT_W-1:0] wk_cnt_r; // Wakeup counter.
    logic [31:0] tick_cnt_r; // Divider for the 1 kHz tick.
    logic ext_s1_r; // External clock synchroniser stages.
    logic ext_s2_r;
    logic ext_s3_r; // Previous synchronised level for edge detect.
    logic lv_s1_r; // Low-voltage event synchroniser.
    logic lv_s2_r;
    // Bus state.
    logic aw_hold_r;
    logic w_hold_r;
    logic [3:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    // Write decode: a write completes when both halves are held.
    wire wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    wire wr_wk = wr_go && w_lane_r && aw_addr_r == ADDR_WAKEUP;
    wire wr_pm = wr_go && w_lane_r && aw_addr_r == ADDR_POWER;
    wire wr_map = aw_addr_r == ADDR_WAKEUP || aw_addr_r == ADDR_POWER ||
                  aw_addr_r == ADDR_PENDING;
    wire wk_ack = wr_wk && w_data_r[WK_ACK_BIT];
    wire lv_ack = wr_pm && w_data_r[LV_ACK_BIT];

    // Wakeup counter source: 1 kHz tick or synchronised external edge.
    wire tick = tick_cnt_r == TICK_DIV - 1;
    wire ext_edge = ext_s2_r && !ext_s3_r;
    wire src_pulse = wk_clks_r ? ext_edge : tick;
    wire [CNT_W-1:0] period = period_of(wk_sel_r, wk_clks_r);
    wire sel_change = wr_wk && w_data_r[2:0] != wk_sel_r;
    wire wk_stop = wk_sel_r == SEL_OFF;
    wire wk_hit = !wk_stop && src_pulse && wk_cnt_r == period - 1'b1;

    // Detection live only when enabled, and in stop only if allowed.
    wire lv_live = lv_de_r && (!stop_mode || lv_se_r);
    wire lv_set = lv_live && lv_s2_r;

    // Pending summary, purely combinational from peripheral flags.
    wire [7:0] pending = {2'b00,
        comparator_flag && comparator_irq_enable,
        conversion_complete_flag && converter_irq_enable,
        (overflow_flag && overflow_irq_enable) ||
        (channel0_flag && channel0_irq_enable) ||
        (channel1_flag && channel1_irq_enable),
        mt2_overflow_flag && mt2_overflow_irq_enable,
        mt1_overflow_flag && mt1_overflow_irq_enable,
        wk_flag_r && wk_ie_r};

    // Read data for each register; acknowledge bits always read zero.
    wire [7:0] wk_rd = {wk_flag_r, 1'b0, wk_clks_r, wk_ie_r, 1'b0, wk_sel_r};
    wire [7:0] pm_rd = {lv_flag_r, 1'b0, lv_ie_r, lv_re_r, lv_se_r, lv_de_r,
                        1'b0, lv_bg_r};
    wire rd_map = s_axi_araddr == ADDR_WAKEUP || s_axi_araddr == ADDR_POWER ||
                  s_axi_araddr == ADDR_PENDING;
    wire [7:0] rd_sel = s_axi_araddr == ADDR_WAKEUP ? wk_rd :
                        s_axi_araddr == ADDR_POWER ? pm_rd :
                        s_axi_araddr == ADDR_PENDING ? pending : 8'h00;

    // Outputs.
    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready = !w_hold_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign wakeup_irq = wk_flag_r && wk_ie_r;
    assign low_voltage_irq = lv_de_r && lv_ie_r && lv_flag_r;
    assign low_voltage_reset = lv_de_r && lv_re_r && lv_flag_r;
    assign low_voltage_detect_on = lv_live;
    assign reference_buffer_on = lv_bg_r;

    // Synchronisers for pin inputs. Both pins are asynchronous to aclk, so
    // only the second stage feeds logic; the third stage only remembers the
    // previous settled level of the external clock for edge detection.
    always_ff @(posedge aclk) begin
        ext_s1_r <= ext_clk_pin;
        ext_s2_r <= ext_s1_r;
        ext_s3_r <= ext_s2_r;
        lv_s1_r <= low_voltage_event;
        lv_s2_r <= lv_s1_r;
    end

    // Tick divider runs free so the internal base is always steady.
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // Wakeup counter and flag; a set wins over an acknowledge.
    always_ff @(posedge aclk) begin
        if (!aresetn || wk_stop || sel_change) begin
            wk_cnt_r <= '0;
        end else if (wk_hit) begin
            wk_cnt_r <= '0;
        end else if (src_pulse) begin
            wk_cnt_r <= wk_cnt_r + 1'b1;
        end
        if (!aresetn) begin
            wk_flag_r <= 1'b0;
        end else if (wk_hit) begin
            wk_flag_r <= 1'b1;
        end else if (wk_ack) begin
            wk_flag_r <= 1'b0;
        end
    end

    // Wakeup control fields.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {wk_clks_r, wk_ie_r} <= WAKEUP_RESET[WK_CLKS_BIT-:2];
            wk_sel_r <= WAKEUP_RESET[WK_SEL_LSB+:3];
        end else if (wr_wk) begin
            wk_clks_r <= w_data_r[WK_CLKS_BIT];
            wk_ie_r <= w_data_r[WK_IE_BIT];
            wk_sel_r <= w_data_r[WK_SEL_LSB+:3];
        end
    end

    // Power monitor register; write-once bits latch on the first write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lv_ie_r <= POWER_RESET[LV_IE_BIT];
            {lv_re_r, lv_se_r, lv_de_r} <= POWER_RESET[LV_RE_BIT-:3];
            lv_bg_r <= POWER_RESET[LV_BG_BIT];
            pm_locked_r <= 1'b0;
        end else if (wr_pm) begin
            lv_ie_r <= w_data_r[LV_IE_BIT];
            lv_se_r <= w_data_r[LV_SE_BIT];
            lv_bg_r <= w_data_r[LV_BG_BIT];
            pm_locked_r <= 1'b1;
            if (!pm_locked_r) begin
                lv_re_r <= w_data_r[LV_RE_BIT];
                lv_de_r <= w_data_r[LV_DE_BIT];
            end
        end
        if (!aresetn) begin
            lv_flag_r <= 1'b0;
        end else if (lv_set) begin
            lv_flag_r <= 1'b1;
        end else if (lv_ack) begin
            lv_flag_r <= 1'b0;
        end
    end

    // AXI write channels: address and data taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_lane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // AXI read channel: one cycle from address to data.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= {24'h000000, rd_sel};
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Checks beside the logic.
    property p_wk_stop;
        @(posedge aclk) disable iff (!aresetn)
        wk_stop |=> wk_cnt_r == '0;
    endproperty
    a_wk_stop: assert property (p_wk_stop)
        else $error("counter not held");
    property p_wk_set;
        @(posedge aclk) disable iff (!aresetn)
        wk_hit |=> wk_flag_r && wk_cnt_r == '0;
    endproperty
    a_wk_set: assert property (p_wk_set)
        else $error("wakeup flag missed");
    property p_wk_ack;
        @(posedge aclk) disable iff (!aresetn)
        wk_ack && !wk_hit |=> !wk_flag_r;
    endproperty
    a_wk_ack: assert property (p_wk_ack)
        else $error("wakeup ack failed");
    // A new delay code must not inherit the count of the old one.
    property p_wk_sel;
        @(posedge aclk) disable iff (!aresetn)
        sel_change |=> wk_cnt_r == '0;
    endproperty
    a_wk_sel: assert property (p_wk_sel)
        else $error("counter not restarted");
    property p_lv_gate;
        @(posedge aclk) disable iff (!aresetn)
        !lv_de_r && !lv_flag_r |=> !lv_flag_r;
    endproperty
    a_lv_gate: assert property (p_lv_gate)
        else $error("flag while off");
    // In stop without stop enable the detector output is ignored.
    property p_lv_stop;
        @(posedge aclk) disable iff (!aresetn)
        stop_mode && !lv_se_r && !lv_flag_r |=> !lv_flag_r;
    endproperty
    a_lv_stop: assert property (p_lv_stop)
        else $error("flag set in stop");
    property p_lv_ack;
        @(posedge aclk) disable iff (!aresetn)
        lv_ack && !lv_set |=> !lv_flag_r;
    endproperty
    a_lv_ack: assert property (p_lv_ack)
        else $error("lv ack failed");
    property p_lv_irq;
        @(posedge aclk) disable iff (!aresetn)
        lv_set && lv_ie_r && !wr_pm |=> low_voltage_irq;
    endproperty
    a_lv_irq: assert property (p_lv_irq)
        else $error("lv request missed");
    property p_once;
        @(posedge aclk) disable iff (!aresetn)
        pm_locked_r |=> $stable(lv_de_r) && $stable(lv_re_r);
    endproperty
    a_once: assert property (p_once)
        else $error("write-once changed");
    property p_rst;
        @(posedge aclk) disable iff (!aresetn)
        lv_set && lv_re_r |=> low_voltage_reset;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset request missed");
    // The read path must return the pending wakeup term seen at the request.
    property p_wk_pend;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && !rvalid_r && s_axi_araddr == ADDR_PENDING |=>
            rdata_r[PD_WK_BIT] == $past(wakeup_irq);
    endproperty
    a_wk_pend: assert property (p_wk_pend)
        else $error("pending 0 wrong");
endmodule : rlpc_sysctl

/* File: bench/rlpc_sysctl_tb.sv */
// Self-checking bench for the system control block over AXI4-Lite.
`timescale 1ns/1ps
module rlpc_sysctl_tb;
    import rlpc_pkg::*;
    localparam int DIV = 4; // Short tick divider keeps wakeup periods brief.
    localparam int EXT_PER = 4; // External clock period in bus cycles.
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic ext_clk = 1'b0;
    logic [1:0] ext_div = 2'h0;
    logic lv_ev = 1'b0, stop = 1'b0;
    logic [13:0] pin = 14'h0; // Peripheral flag and enable levels.
    logic wk_irq, lv_irq, lv_rst, lv_on, buf_on;
    int n_fail = 0;
    int checks = 0;
    int seed = 32'h64e8;
    // Source periods per delay code 001..111, internal and external.
    int ms_t[7] = '{8, 32, 64, 128, 256, 512, 1024};
    int ext_t[7] = '{256, 1024, 2048, 4096, 8192, 16384, 32768};

    rlpc_sysctl #(.TICK_DIV(DIV)) rlpc_sysctl_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_clk_pin(ext_clk), .low_voltage_event(lv_ev), .stop_mode(stop),
        .comparator_flag(pin[0]), .comparator_irq_enable(pin[1]),
        .conversion_complete_flag(pin[2]), .converter_irq_enable(pin[3]),
        .overflow_flag(pin[4]), .overflow_irq_enable(pin[5]),
        .channel0_flag(pin[6]), .channel0_irq_enable(pin[7]),
        .channel1_flag(pin[8]), .channel1_irq_enable(pin[9]),
        .mt1_overflow_flag(pin[10]), .mt1_overflow_irq_enable(pin[11]),
        .mt2_overflow_flag(pin[12]), .mt2_overflow_irq_enable(pin[13]),
        .wakeup_irq(wk_irq), .low_voltage_irq(lv_irq),
        .low_voltage_reset(lv_rst), .low_voltage_detect_on(lv_on),
        .reference_buffer_on(buf_on)
    );

    // Bus clock at 40 MHz.
    always #12.5 aclk = ~aclk;

    // External wakeup clock, slow enough for the design's synchroniser.
    always @(posedge aclk) begin
        ext_div <= ext_div + 2'h1;
        ext_clk <= ext_div[1];
    end

    // Compares one result; four-state equality so unknowns never match.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run; the only exit of the bench.
    task automatic tally_and_finish;
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One write; address and data go together, each released when taken.
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic aw_ok, w_ok;
        int n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        // Let an edge pass so no handshake signal is driven twice at once.
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok) && n < 50) begin
            @(posedge aclk);
            n++;
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        // Response is awaited with bready held high until bvalid is seen.
        do begin
            @(posedge aclk);
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        check({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
    endtask

    // One read, returning data; rready is held until rvalid is seen.
    task automatic rd(input logic [3:0] a, input logic [1:0] er,
                      output logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        d = rdata;
        rready <= 1'b0;
        check({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
    endtask

    // Reads a mapped register and compares it with the expectation.
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, RESP_OKAY, d);
        check(d, exp);
    endtask

    // Expected pending summary from the peripheral levels and wakeup term.
    function automatic logic [31:0] pend_m(input logic [13:0] p,
                                           input logic wk);
        return {26'h0, p[0] & p[1], p[2] & p[3],
                (p[4] & p[5]) | (p[6] & p[7]) | (p[8] & p[9]),
                p[12] & p[13], p[10] & p[11], wk};
    endfunction

    // Times one wakeup period from the code write to the interrupt request.
    // The tick prescaler phase is unknown, so one source period of slack.
    task automatic period(input logic ck, input logic [2:0] code,
                          input int n_src, input int per);
        int n;
        int lo;
        int hi;
        logic [31:0] e;
        n = 0;
        lo = (n_src - 1) * per - 4;
        hi = n_src * per + 10;
        wr(ADDR_WAKEUP, {2'b01, ck, 1'b1, 4'h0}, 4'h1, RESP_OKAY);
        wr(ADDR_WAKEUP, {2'b00, ck, 1'b1, 1'b0, code}, 4'h1, RESP_OKAY);
        while (wk_irq !== 1'b1 && n < hi + 4) begin
            @(posedge aclk);
            n++;
        end
        check({31'h0, n >= lo && n <= hi}, 32'h1);
        e = {24'h0, 2'b10, ck, 1'b1, 1'b0, code};
        rd_chk(ADDR_WAKEUP, e);
        rd_chk(ADDR_PENDING, 32'h1);
    endtask

    // Main sequence.
    initial begin
        logic [31:0] d;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(ADDR_WAKEUP, {24'h0, WAKEUP_RESET});
        rd_chk(ADDR_PENDING, 32'h0);
        // Unmapped place answers with an error on both paths.
        rd(4'hC, RESP_SLVERR, d);
        wr(4'hC, 8'hFF, 4'h1, RESP_SLVERR);
        // A low-voltage event with detection off must leave no trace.
        lv_ev <= 1'b1;
        repeat (10) @(posedge aclk);
        rd_chk(ADDR_POWER, {24'h0, POWER_RESET});
        check({29'h0, lv_irq, lv_rst, lv_on}, 32'h0);
        lv_ev <= 1'b0;
        // First write locks the write-once bits; later writes cannot move them.
        wr(ADDR_POWER, 8'h3D, 4'h1, RESP_OKAY);
        rd_chk(ADDR_POWER, 32'h3D);
        check({30'h0, lv_on, buf_on}, 32'h3);
        wr(ADDR_POWER, 8'h00, 4'h1, RESP_OKAY);
        rd_chk(ADDR_POWER, 32'h14);
        check({30'h0, lv_on, buf_on}, 32'h2);
        wr(ADDR_POWER, 8'h29, 4'h0, RESP_OKAY);
        rd_chk(ADDR_POWER, 32'h14);
        // Stop mode without stop enable blocks detection.
        wr(ADDR_POWER, 8'h20, 4'h1, RESP_OKAY);
        stop <= 1'b1;
        lv_ev <= 1'b1;
        repeat (10) @(posedge aclk);
        rd_chk(ADDR_POWER, 32'h34);
        stop <= 1'b0;
        repeat (10) @(posedge aclk);
        rd_chk(ADDR_POWER, 32'hB4);
        check({30'h0, lv_irq, lv_rst}, 32'h3);
        lv_ev <= 1'b0;
        // Let the synchronised event drain so the set cannot beat the ack.
        repeat (3) @(posedge aclk);
        wr(ADDR_POWER, 8'h60, 4'h1, RESP_OKAY);
        rd_chk(ADDR_POWER, 32'h34);
        check({30'h0, lv_irq, lv_rst}, 32'h0);
        // With stop enable set, detection stays alive in stop mode.
        wr(ADDR_POWER, 8'h08, 4'h1, RESP_OKAY);
        stop <= 1'b1;
        lv_ev <= 1'b1;
        repeat (10) @(posedge aclk);
        rd_chk(ADDR_POWER, 32'h9C);
        check({31'h0, lv_irq}, 32'h0);
        lv_ev <= 1'b0;
        stop <= 1'b0;
        repeat (3) @(posedge aclk);
        wr(ADDR_POWER, 8'h48, 4'h1, RESP_OKAY);
        rd_chk(ADDR_POWER, 32'h1C);
        // Every internal delay code, then the two shortest external ones.
        for (int k = 1; k <= 7; k++) begin
            period(1'b0, k[2:0], ms_t[k-1], DIV);
        end
        for (int k = 1; k <= 2; k++) begin
            period(1'b1, k[2:0], ext_t[k-1], EXT_PER);
        end
        // Enable off: the flag still sets but no request is made.
        wr(ADDR_WAKEUP, 8'h40, 4'h1, RESP_OKAY);
        wr(ADDR_WAKEUP, 8'h01, 4'h1, RESP_OKAY);
        // The wait ends between two timeouts so the later ack cannot meet one.
        repeat (40) @(posedge aclk);
        check({31'h0, wk_irq}, 32'h0);
        rd_chk(ADDR_WAKEUP, 32'h81);
        rd_chk(ADDR_PENDING, 32'h0);
        // Code zero holds the counter cleared, so no timeout ever comes.
        wr(ADDR_WAKEUP, 8'h50, 4'h1, RESP_OKAY);
        repeat (60) @(posedge aclk);
        check({31'h0, wk_irq}, 32'h0);
        rd_chk(ADDR_WAKEUP, 32'h10);
        // Random peripheral levels against the pending summary model.
        for (int i = 0; i < 40; i++) begin
            pin <= 14'($random(seed));
            @(posedge aclk);
            d = pend_m(pin, 1'b0);
            rd_chk(ADDR_PENDING, d);
        end
        pin <= 14'h0;
        @(posedge aclk);
        rd_chk(ADDR_PENDING, 32'h0);
        tally_and_finish();
    end

    // Watchdog sized well beyond the expected run of some 14000 cycles.
    initial begin
        repeat (60000) @(posedge aclk);
        n_fail++;
        tally_and_finish();
    end
endmodule // rlpc_sysctl_tb
